// file: swwd_params.svh
`ifndef SWWD_PARAMS_SVH
`define SWWD_PARAMS_SVH
// Oscillator period and one millisecond, both in ns
`define SWWD_CLK_NS       100
`define SWWD_MS_NS        1000000
`define SWWD_MS_CYCLES    (`SWWD_MS_NS / `SWWD_CLK_NS)
// Period code n selects 16 ms shifted left by n; 6 is the 1024 ms limit
`define SWWD_BASE_MS      11'h010
`define SWWD_CODE_DEF     3'h4
`define SWWD_CODE_MAX     3'h6
// Control word layout
`define SWWD_WORD_W       16
`define SWWD_F_MODE_HI    15
`define SWWD_F_MODE_LO    13
`define SWWD_F_REFRESH    12
`define SWWD_F_CFG_WR     11
`define SWWD_F_WINDOW     10
`define SWWD_F_PER_HI     9
`define SWWD_F_PER_LO     7
`define SWWD_F_WD_OFF     6
`define SWWD_F_WAKE_RD    5
// Chip mode codes, shared by the mode input and the word's mode field
`define SWWD_M_INIT       3'h0
`define SWWD_M_NORMAL     3'h1
`define SWWD_M_STOP       3'h2
`define SWWD_M_FLASH      3'h3
`define SWWD_M_SLEEP      3'h4
`define SWWD_M_FAILSAFE   3'h5
`define SWWD_M_RESTART    3'h6
`define SWWD_M_READONLY   3'h7
// Status codes recorded on a watchdog failure
`define SWWD_CAUSE_WD     2'h2
`define SWWD_LIMP_WD      3'h1
`endif

// file: swwd_pkg.sv
package swwd_pkg;
	typedef enum logic [2:0] {WD_OFF, WD_IDLE, WD_RUN, WD_INH, WD_FAIL} swwd_state_t;

	// Logic on the oscillator clock
	typedef struct packed {
		swwd_state_t state;
		logic        win;
		logic [2:0]  code;
		logic [10:0] ms;
		logic [15:0] sub;
		logic        ref_bit;
		logic        tsync1;
		logic        tsync2;
		logic        tseen;
		logic        cs1;
		logic        cs2;
		logic        cs3;
		logic        pend;
		logic        ack_pend;
		logic        reset_n;
		logic        int_n;
		logic        rst_stat;
		logic        bad;
		logic [1:0]  cause;
		logic [2:0]  limp;
		logic        go_restart;
		logic        go_failsafe;
	} swwd_core_t;

	// Logic on the serial clock
	typedef struct packed {
		logic [15:0] sh;
		logic [3:0]  cnt;
		logic [15:0] word;
		logic        tog;
	} swwd_link_t;
endpackage

// file: swwd_watchdog.sv
`timescale 1ns/100ps
`include "swwd_params.svh"

module swwd_watchdog #(
	parameter int MS_CYCLES = `SWWD_MS_CYCLES
) (
	// Clock and reset
	input  wire logic       REF_CLK,
	input  wire logic       ARST_N,
	// Serial link
	input  wire logic       SPI_CLK,
	input  wire logic       SPI_MOSI,
	input  wire logic       CHIP_SELECT_LOW,
	// Chip context
	input  wire logic [2:0] SBC_MODE,
	input  wire logic       SW_DEV_MODE,
	input  wire logic [1:0] FAIL_CFG,
	input  wire logic       CYCLIC_WAKE,
	input  wire logic       INT_MASK,
	input  wire logic       STATUS_CLEAR,
	// Pins and requests
	output logic            RESET_OUT_PIN_N,
	output logic            INT_PIN_N,
	output logic            GO_RESTART,
	output logic            GO_FAILSAFE,
	// Status bits
	output logic            RESET_STATUS_BIT,
	output logic            BAD_SETTING_FLAG,
	output logic            RESTART_CAUSE_BIT0,
	output logic            RESTART_CAUSE_BIT1,
	output logic            LIMP_STATE_BIT0,
	output logic            LIMP_STATE_BIT1,
	output logic            LIMP_STATE_BIT2,
	output logic            WD_RUNNING
);
	localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

	swwd_pkg::swwd_link_t lk;
	swwd_pkg::swwd_link_t next_lk;
	swwd_pkg::swwd_core_t s;
	swwd_pkg::swwd_core_t next_s;

	logic [`SWWD_WORD_W-1:0] word;
	logic [2:0]              sel;
	logic [10:0]             per;
	logic                    take;
	logic                    sel_ok;
	logic                    toggled;
	logic                    tick;
	logic                    early;
	logic                    fail;
	logic                    new_ok;

	// Period in ms for a code
	function automatic logic [10:0] per_ms(input logic [2:0] code);
		per_ms = `SWWD_BASE_MS << code;
	endfunction

	// Modes in which the watchdog is switched off
	function automatic logic off_mode(input logic [2:0] m);
		off_mode = (m == `SWWD_M_SLEEP) || (m == `SWWD_M_FAILSAFE) || (m == `SWWD_M_RESTART);
	endfunction

	// Link side: shift 16 bits, then publish the word and flip the toggle.
	// A frame cut short leaves the bit count off; the next full frame is
	// misaligned, a limitation of running only on the serial clock.
	always_comb
	begin
		next_lk = lk;
		next_lk.sh = {lk.sh[14:0], SPI_MOSI};
		next_lk.cnt = lk.cnt + 4'h1;
		if (lk.cnt == 4'hf)
		begin
			next_lk.word = {lk.sh[14:0], SPI_MOSI};
			next_lk.tog = ~lk.tog;
		end
	end

	// Link register
	always_ff @(posedge SPI_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			lk <= '0;
		else
			lk <= next_lk;
	end

	// Core next state
	always_comb
	begin
		next_s = s;
		word = lk.word;
		sel = word[`SWWD_F_MODE_HI:`SWWD_F_MODE_LO];
		per = per_ms(s.code);
		fail = 1'b0;
		new_ok = word[`SWWD_F_PER_HI:`SWWD_F_PER_LO] <= `SWWD_CODE_MAX;
		// Word toggle and chip select cross by two flops each
		next_s.tsync1 = lk.tog;
		next_s.tsync2 = s.tsync1;
		next_s.cs1 = CHIP_SELECT_LOW;
		next_s.cs2 = s.cs1;
		next_s.cs3 = s.cs2;
		// Word is stable once its toggle is seen; it is used on select release
		take = s.pend && s.cs2 && !s.cs3;
		if (take)
			next_s.pend = 1'b0;
		if (s.tsync2 != s.tseen)
		begin
			next_s.tseen = s.tsync2;
			next_s.pend = 1'b1;
		end
		sel_ok = (sel == `SWWD_M_NORMAL) || (sel == `SWWD_M_STOP) || (sel == `SWWD_M_FLASH)
			|| (sel == `SWWD_M_READONLY);
		toggled = take && sel_ok && (word[`SWWD_F_REFRESH] != s.ref_bit);
		early = s.win && (s.ms < (per >> 1));
		// Millisecond tick from the oscillator
		tick = (s.sub == MS_LAST);
		next_s.sub = tick ? 16'h0000 : s.sub + 16'h0001;
		next_s.int_n = 1'b1;
		// Status clear first so that a same-cycle event still sets
		if (STATUS_CLEAR)
		begin
			next_s.rst_stat = 1'b0;
			next_s.bad = 1'b0;
		end
		case (s.state)
			swwd_pkg::WD_OFF:
			begin
				// Configuration discarded while off
				next_s.code = `SWWD_CODE_DEF;
				next_s.win = 1'b0;
				next_s.ref_bit = 1'b0;
				next_s.ms = 11'h000;
				next_s.ack_pend = 1'b0;
				if (SBC_MODE == `SWWD_M_NORMAL)
					next_s.state = swwd_pkg::WD_RUN;
				else if (SBC_MODE == `SWWD_M_INIT)
					next_s.state = swwd_pkg::WD_IDLE;
			end
			swwd_pkg::WD_IDLE:
			begin
				// Programmable, timer held
				next_s.ms = 11'h000;
				if (take && word[`SWWD_F_CFG_WR])
				begin
					if (new_ok)
					begin
						next_s.code = word[`SWWD_F_PER_HI:`SWWD_F_PER_LO];
						next_s.win = word[`SWWD_F_WINDOW];
					end
					else
					begin
						next_s.bad = 1'b1;
						next_s.int_n = INT_MASK;
					end
				end
				if (off_mode(SBC_MODE))
					next_s.state = swwd_pkg::WD_OFF;
				else if (SBC_MODE == `SWWD_M_NORMAL)
				begin
					next_s.state = swwd_pkg::WD_RUN;
					next_s.sub = 16'h0000;
				end
			end
			swwd_pkg::WD_RUN:
			begin
				if (tick)
					next_s.ms = s.ms + 11'h001;
				// Wake status read clears the pending acknowledge
				if (take && word[`SWWD_F_WAKE_RD])
					next_s.ack_pend = 1'b0;
				if (off_mode(SBC_MODE))
					next_s.state = swwd_pkg::WD_OFF;
				else if (toggled && early)
					fail = 1'b1;
				else if (toggled)
				begin
					// Service restarts the period, closed half first in window mode
					next_s.ms = 11'h000;
					next_s.sub = 16'h0000;
					next_s.ref_bit = word[`SWWD_F_REFRESH];
					// While running, written settings only take in normal mode, alongside a good toggle
					if (word[`SWWD_F_CFG_WR] && SBC_MODE == `SWWD_M_NORMAL)
					begin
						if (new_ok)
						begin
							next_s.code = word[`SWWD_F_PER_HI:`SWWD_F_PER_LO];
							next_s.win = word[`SWWD_F_WINDOW];
						end
						else
						begin
							next_s.bad = 1'b1;
							next_s.int_n = INT_MASK;
						end
					end
					if (word[`SWWD_F_WD_OFF])
					begin
						if (SBC_MODE == `SWWD_M_STOP || SBC_MODE == `SWWD_M_FLASH)
							next_s.state = swwd_pkg::WD_INH;
						else
						begin
							next_s.bad = 1'b1;
							next_s.int_n = INT_MASK;
						end
					end
				end
				else if (take && word[`SWWD_F_WD_OFF])
				begin
					// Inhibit without a proper toggle is refused
					next_s.bad = 1'b1;
					next_s.int_n = INT_MASK;
				end
				else if (tick && (s.ms + 11'h001 >= per))
					fail = 1'b1;
				// Cyclic wake in stop mode needs the wake status read in between
				if (CYCLIC_WAKE && SBC_MODE == `SWWD_M_STOP && !off_mode(SBC_MODE))
				begin
					if (s.ack_pend && !(take && word[`SWWD_F_WAKE_RD]))
						fail = 1'b1;
					else
						next_s.ack_pend = 1'b1;
				end
			end
			swwd_pkg::WD_INH:
			begin
				// Settings frozen; the last written refresh bit is the reference
				if (take && sel_ok)
					next_s.ref_bit = word[`SWWD_F_REFRESH];
				next_s.ack_pend = 1'b0;
				if (off_mode(SBC_MODE))
					next_s.state = swwd_pkg::WD_OFF;
				else if (SBC_MODE == `SWWD_M_NORMAL)
				begin
					next_s.state = swwd_pkg::WD_RUN;
					next_s.ms = 11'h000;
					next_s.sub = 16'h0000;
				end
			end
			default:
			begin
				// Held in reset until the chip enters sleep, fail-safe or restart mode
				if (off_mode(SBC_MODE))
				begin
					next_s.state = swwd_pkg::WD_OFF;
					next_s.reset_n = 1'b1;
					next_s.go_restart = 1'b0;
					next_s.go_failsafe = 1'b0;
				end
			end
		endcase
		// Failure reaction
		if (fail && SW_DEV_MODE)
		begin
			// Development mode reports and restarts with the default long window
			next_s.rst_stat = 1'b1;
			next_s.int_n = 1'b0;
			next_s.code = `SWWD_CODE_DEF;
			next_s.win = 1'b0;
			next_s.ref_bit = 1'b0;
			next_s.ms = 11'h000;
			next_s.sub = 16'h0000;
			next_s.ack_pend = 1'b0;
		end
		else if (fail)
		begin
			next_s.state = swwd_pkg::WD_FAIL;
			next_s.reset_n = 1'b0;
			next_s.cause = `SWWD_CAUSE_WD;
			// Configurations 1 and 3 go to restart, 0 and 2 to fail-safe
			next_s.go_restart = FAIL_CFG[0];
			next_s.go_failsafe = !FAIL_CFG[0];
			if (!FAIL_CFG[0])
				next_s.limp = `SWWD_LIMP_WD;
		end
	end

	// Core register
	always_ff @(posedge REF_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			s <= '0;
			s.code <= `SWWD_CODE_DEF;
			s.reset_n <= 1'b1;
			s.int_n <= 1'b1;
			s.cs1 <= 1'b1;
			s.cs2 <= 1'b1;
			s.cs3 <= 1'b1;
		end
		else
			s <= next_s;
	end

	// Ports straight from flops; WD_RUNNING is decoded from the state
	assign RESET_OUT_PIN_N = s.reset_n;
	assign INT_PIN_N = s.int_n;
	assign GO_RESTART = s.go_restart;
	assign GO_FAILSAFE = s.go_failsafe;
	assign RESET_STATUS_BIT = s.rst_stat;
	assign BAD_SETTING_FLAG = s.bad;
	assign RESTART_CAUSE_BIT0 = s.cause[0];
	assign RESTART_CAUSE_BIT1 = s.cause[1];
	assign LIMP_STATE_BIT0 = s.limp[0];
	assign LIMP_STATE_BIT1 = s.limp[1];
	assign LIMP_STATE_BIT2 = s.limp[2];
	assign WD_RUNNING = (s.state == swwd_pkg::WD_RUN);

	property p_boot;
		@(posedge REF_CLK) disable iff (!ARST_N)
		s.state == swwd_pkg::WD_OFF && SBC_MODE == `SWWD_M_NORMAL |=> s.state == swwd_pkg::WD_RUN
			&& s.code == `SWWD_CODE_DEF && !s.win;
	endproperty
	a_boot: assert property (p_boot) else $error("watchdog did not start default");

	property p_service;
		@(posedge REF_CLK) disable iff (!ARST_N)
		s.state == swwd_pkg::WD_RUN && toggled && !early && !off_mode(SBC_MODE) |=> s.ms == 11'h000
			&& s.ref_bit == $past(word[`SWWD_F_REFRESH]);
	endproperty
	a_service: assert property (p_service) else $error("service did not restart period");

	property p_expire;
		@(posedge REF_CLK) disable iff (!ARST_N)
		s.state == swwd_pkg::WD_RUN && tick && s.ms + 11'h001 >= per && !take && !SW_DEV_MODE
			&& !off_mode(SBC_MODE) |=> !RESET_OUT_PIN_N ##1 !RESET_OUT_PIN_N || off_mode($past(SBC_MODE));
	endproperty
	a_expire: assert property (p_expire) else $error("missed service gave no reset");

	property p_swdev;
		@(posedge REF_CLK) disable iff (!ARST_N)
		fail && SW_DEV_MODE |=> RESET_OUT_PIN_N && RESET_STATUS_BIT && !INT_PIN_N && s.ms == 11'h000;
	endproperty
	a_swdev: assert property (p_swdev) else $error("development mode failure misreported");

	property p_closed;
		@(posedge REF_CLK) disable iff (!ARST_N)
		s.state == swwd_pkg::WD_RUN && toggled && early && !SW_DEV_MODE && !off_mode(SBC_MODE)
			|=> s.state == swwd_pkg::WD_FAIL && GO_RESTART == $past(FAIL_CFG[0]);
	endproperty
	a_closed: assert property (p_closed) else $error("closed window toggle accepted");

	property p_badset;
		@(posedge REF_CLK) disable iff (!ARST_N)
		s.state == swwd_pkg::WD_RUN && toggled && !early && word[`SWWD_F_CFG_WR] && !new_ok
			&& SBC_MODE == `SWWD_M_NORMAL |=> BAD_SETTING_FLAG && s.code == $past(s.code);
	endproperty
	a_badset: assert property (p_badset) else $error("invalid setting not refused");

	property p_off;
		@(posedge REF_CLK) disable iff (!ARST_N)
		s.state != swwd_pkg::WD_FAIL && off_mode(SBC_MODE) && off_mode($past(SBC_MODE)) |=>
			!WD_RUNNING && s.ref_bit == 1'b0 && s.code == `SWWD_CODE_DEF;
	endproperty
	a_off: assert property (p_off) else $error("watchdog kept setup while off");

	property p_fixed;
		@(posedge REF_CLK) disable iff (!ARST_N)
		s.state == swwd_pkg::WD_RUN && SBC_MODE == `SWWD_M_STOP && !fail |=> s.code == $past(s.code)
			&& s.win == $past(s.win);
	endproperty
	a_fixed: assert property (p_fixed) else $error("setup changed in stop mode");

	property p_return;
		@(posedge REF_CLK) disable iff (!ARST_N)
		s.state == swwd_pkg::WD_INH && SBC_MODE == `SWWD_M_NORMAL |=> WD_RUNNING && s.ms == 11'h000
			&& s.code == $past(s.code);
	endproperty
	a_return: assert property (p_return) else $error("return from inhibit mistimed");
endmodule

// file: swwd_host_model.sv
`timescale 1ns/100ps
module swwd_host_model (
	// Serial link toward the watchdog
	output logic spi_clk,
	output logic spi_mosi,
	output logic cs_low
);
	// Link clock stands still between frames
	initial
	begin
		spi_clk = 1'b0;
		spi_mosi = 1'b1;
		cs_low = 1'b1;
	end

	// One frame, MSB first, 32 ns link clock; data set while clock is low
	task automatic send(input logic [15:0] word);
		int i;
		cs_low = 1'b0;
		for (i = 15; i >= 0; i--)
		begin
			spi_mosi = word[i];
			#16 spi_clk = 1'b1;
			#16 spi_clk = 1'b0;
		end
		// Select held until the word toggle has crossed to the oscillator side
		#400 cs_low = 1'b1;
		// Released line shows the inverse so a stale bit is never reused
		spi_mosi = ~word[0];
	endtask
endmodule

// file: sbc_window_timeout_watchdog_tb.sv
`timescale 1ns/100ps
`include "swwd_params.svh"
module sbc_window_timeout_watchdog_tb;
	logic REF_CLK = 1'b0;
	logic ARST_N = 1'b0;
	logic [2:0] SBC_MODE = `SWWD_M_INIT;
	logic SW_DEV_MODE = 1'b0;
	logic [1:0] FAIL_CFG = 2'h1;
	logic CYCLIC_WAKE = 1'b0;
	logic INT_MASK = 1'b0;
	logic STATUS_CLEAR = 1'b0;
	wire logic spi_clk, spi_mosi, cs_low;
	logic rst_pin, int_pin, go_rs, go_fs, rst_stat, bad, c0, c1, l0, l1, l2, run;
	int miscompares = 0;
	int num_checks = 0;
	int icnt = 0;
	int cyc = 0;

	// Short millisecond so a 1024 ms period stays 10240 cycles
	swwd_watchdog #(.MS_CYCLES(10)) i_dut (
		.REF_CLK(REF_CLK), .ARST_N(ARST_N), .SPI_CLK(spi_clk), .SPI_MOSI(spi_mosi),
		.CHIP_SELECT_LOW(cs_low), .SBC_MODE(SBC_MODE), .SW_DEV_MODE(SW_DEV_MODE),
		.FAIL_CFG(FAIL_CFG), .CYCLIC_WAKE(CYCLIC_WAKE), .INT_MASK(INT_MASK),
		.STATUS_CLEAR(STATUS_CLEAR), .RESET_OUT_PIN_N(rst_pin), .INT_PIN_N(int_pin),
		.GO_RESTART(go_rs), .GO_FAILSAFE(go_fs), .RESET_STATUS_BIT(rst_stat),
		.BAD_SETTING_FLAG(bad), .RESTART_CAUSE_BIT0(c0), .RESTART_CAUSE_BIT1(c1),
		.LIMP_STATE_BIT0(l0), .LIMP_STATE_BIT1(l1), .LIMP_STATE_BIT2(l2), .WD_RUNNING(run));
	swwd_host_model i_host (.spi_clk(spi_clk), .spi_mosi(spi_mosi), .cs_low(cs_low));

	// 10 MHz oscillator
	always #50 REF_CLK = ~REF_CLK;

	// Interrupt pulses are one cycle wide, so count them as they pass
	always @(posedge REF_CLK)
	begin
		if (int_pin === 1'b0)
			icnt++;
		cyc++;
		if (cyc == 20000)
		begin
			miscompares++;
			end_sim();
		end
	end

	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [3:0] exp, input logic [3:0] got);
		num_checks++;
		if (got !== exp)
		begin
			$display("Error %s expected %h seen %h", name, exp, got);
			miscompares++;
		end
	endtask

	task automatic wc(input int n);
		repeat (n) @(posedge REF_CLK);
	endtask

	function automatic logic [15:0] w(logic [2:0] m, logic r, logic c, logic wn, logic [2:0] p, logic off);
		return {m, r, c, wn, p, off, 1'b0, 5'h00};
	endfunction

	// Frame, then let the take and the answer land
	task automatic srv(input logic [15:0] word);
		i_host.send(word);
		wc(6);
	endtask

	task automatic mode(input logic [2:0] m);
		@(posedge REF_CLK);
		SBC_MODE <= m;
		wc(4);
	endtask

	task automatic do_reset(input logic [1:0] fc, input logic dev);
		@(posedge REF_CLK);
		ARST_N <= 1'b0;
		SBC_MODE <= `SWWD_M_INIT;
		FAIL_CFG <= fc;
		SW_DEV_MODE <= dev;
		INT_MASK <= 1'b0;
		wc(4);
		ARST_N <= 1'b1;
		wc(2);
	endtask

	// Default long window, expiry, restart and first service after it
	task automatic t_default();
		do_reset(2'h1, 1'b0);
		chk("running", 4'h0, {3'h0, run});
		mode(`SWWD_M_NORMAL);
		chk("running", 4'h1, {3'h0, run});
		wc(2490);
		chk("reset_pin", 4'h1, {3'h0, rst_pin});
		wc(106);
		chk("reset_pin", 4'h0, {3'h0, rst_pin});
		chk("go_restart", 4'h1, {3'h0, go_rs});
		chk("cause", 4'h2, {2'h0, c1, c0});
		mode(`SWWD_M_RESTART);
		chk("running", 4'h0, {3'h0, run});
		mode(`SWWD_M_NORMAL);
		srv(w(`SWWD_M_NORMAL, 1'b1, 1'b1, 1'b0, 3'h0, 1'b0));
		wc(135);
		chk("reset_pin", 4'h1, {3'h0, rst_pin});
		wc(40);
		chk("reset_pin", 4'h0, {3'h0, rst_pin});
		$display("test default done");
	endtask

	// Window mode: open-window service, then a closed-window toggle
	task automatic t_window();
		do_reset(2'h0, 1'b0);
		mode(`SWWD_M_NORMAL);
		srv(w(`SWWD_M_NORMAL, 1'b1, 1'b1, 1'b1, 3'h0, 1'b0));
		wc(100);
		srv(w(`SWWD_M_READONLY, 1'b0, 1'b0, 1'b0, 3'h0, 1'b0));
		chk("reset_pin", 4'h1, {3'h0, rst_pin});
		wc(20);
		srv(w(`SWWD_M_STOP, 1'b1, 1'b0, 1'b0, 3'h0, 1'b0));
		chk("reset_pin", 4'h0, {3'h0, rst_pin});
		chk("go_failsafe", 4'h1, {3'h0, go_fs});
		chk("limp", 4'h1, {1'h0, l2, l1, l0});
		$display("test window done");
	endtask

	// Invalid period code and an off request outside stop or flash
	task automatic t_bad();
		do_reset(2'h1, 1'b0);
		mode(`SWWD_M_NORMAL);
		icnt = 0;
		srv(w(`SWWD_M_NORMAL, 1'b1, 1'b1, 1'b0, 3'h7, 1'b0));
		chk("bad_flag", 4'h1, {3'h0, bad});
		chk("int_pulses", 4'h1, icnt[3:0]);
		@(posedge REF_CLK);
		STATUS_CLEAR <= 1'b1;
		@(posedge REF_CLK);
		STATUS_CLEAR <= 1'b0;
		INT_MASK <= 1'b1;
		wc(2);
		chk("bad_flag", 4'h0, {3'h0, bad});
		icnt = 0;
		srv(w(`SWWD_M_NORMAL, 1'b0, 1'b0, 1'b0, 3'h0, 1'b1));
		chk("bad_flag", 4'h1, {3'h0, bad});
		chk("int_pulses", 4'h0, icnt[3:0]);
		chk("running", 4'h1, {3'h0, run});
		$display("test bad done");
	endtask

	// Time-out restart by a toggle, a repeated bit ignored, then dev-mode failure
	task automatic t_tout();
		do_reset(2'h1, 1'b1);
		mode(`SWWD_M_NORMAL);
		srv(w(`SWWD_M_NORMAL, 1'b1, 1'b1, 1'b0, 3'h0, 1'b0));
		wc(100);
		srv(w(`SWWD_M_NORMAL, 1'b0, 1'b0, 1'b0, 3'h0, 1'b0));
		wc(100);
		chk("reset_status", 4'h0, {3'h0, rst_stat});
		icnt = 0;
		srv(w(`SWWD_M_NORMAL, 1'b0, 1'b0, 1'b0, 3'h0, 1'b0));
		wc(70);
		chk("reset_status", 4'h1, {3'h0, rst_stat});
		chk("reset_pin", 4'h1, {3'h0, rst_pin});
		chk("int_pulses", 4'h1, icnt[3:0]);
		$display("test tout done");
	endtask

	// Inhibit in stop mode, return to normal, then an unacknowledged cyclic wake
	task automatic t_inh();
		do_reset(2'h1, 1'b0);
		mode(`SWWD_M_NORMAL);
		srv(w(`SWWD_M_NORMAL, 1'b1, 1'b0, 1'b0, 3'h0, 1'b0));
		mode(`SWWD_M_STOP);
		srv(w(`SWWD_M_STOP, 1'b0, 1'b0, 1'b0, 3'h0, 1'b1));
		chk("running", 4'h0, {3'h0, run});
		wc(2700);
		chk("reset_pin", 4'h1, {3'h0, rst_pin});
		mode(`SWWD_M_NORMAL);
		chk("running", 4'h1, {3'h0, run});
		mode(`SWWD_M_STOP);
		repeat (2)
		begin
			@(posedge REF_CLK);
			CYCLIC_WAKE <= 1'b1;
			@(posedge REF_CLK);
			CYCLIC_WAKE <= 1'b0;
			wc(3);
		end
		chk("reset_pin", 4'h0, {3'h0, rst_pin});
		chk("go_restart", 4'h1, {3'h0, go_rs});
		$display("test inh done");
	endtask

	initial
	begin
		t_default();
		t_window();
		t_bad();
		t_tout();
		t_inh();
		end_sim();
	end
endmodule
